// ===== hw/paging_message_packet_sequencer.v
// walks one decoded paging frame and emits host packets in order
//
// Summary of operation
// RQ1 - walk frame by block, then phase, fully
// RQ2 - never forward word 0 block info
// RQ3 - extra block info sent only when enabled
// RQ4 - forward only words meant for this pager
// RQ5 - address packet first, vector packet later
// RQ6 - address packet carries its vector word number
// RQ7 - two-word long address makes one packet
// RQ8 - word after long vector is first message
// RQ9 - phase count one, two, four by rate
// RQ10 - message packets carry word number, phase, ascending
// RQ11 - host relates address, vector, message packets
// RQ12 - host may use block info for time
// RQ13 - packets leave in production order
`timescale 1ns/1ps
`include "pager_seq_regs.vh"
module paging_message_packet_sequencer #(
   parameter WN_W     = 7,  // word number width
   parameter DATA_W   = 21, // decoded word payload width
   parameter BLOCKS   = 11  // blocks in a frame
) (
   input  wire              clock,        // 20 MHz system clock
   input  wire              rstn,         // async reset, active low
   input  wire              frameStart,   // pulse: decoded frame ready in store
   input  wire [1:0]        signalRate,   // rate code sampled at frameStart
   input  wire              blockInfoEn,  // forward extra block info words
   input  wire              wordWe,       // write a decoded word into store
   input  wire [1:0]        wordPhase,    // phase of written word
   input  wire [WN_W-1:0]   wordNumber,   // word number of written word
   input  wire [2:0]        wordKind,     // classification of written word
   input  wire [DATA_W-1:0] wordData,     // payload of written word
   input  wire [WN_W-1:0]   wordLink,     // vector location or message start
   input  wire [WN_W-1:0]   wordLen,      // message word count from vector
   output wire              busy,         // frame walk in progress
   output wire              pktValid,     // packet available to host link
   input  wire              pktReady,     // host link accepts packet
   output wire [2:0]        pktType,      // packet type
   output wire [1:0]        pktPhase,     // phase of packet
   output wire [WN_W-1:0]   pktWordNum,   // word number field
   output wire [DATA_W-1:0] pktData       // payload field
);
   localparam DEPTH  = 1 << WN_W;
   localparam PKT_W  = 3 + 2 + WN_W + DATA_W;
   localparam S_IDLE = 2'h0;
   localparam S_SCAN = 2'h1;
   localparam S_EMIT = 2'h2;

   // decoded frame store, one entry per phase and word
   reg [2:0]        kindMem [0:4*DEPTH-1];
   reg [DATA_W-1:0] dataMem [0:4*DEPTH-1];
   reg [WN_W-1:0]   linkMem [0:4*DEPTH-1];
   reg [WN_W-1:0]   lenMem  [0:4*DEPTH-1];
   // per-phase/word flag: word is a message for us, marked by a vector
   reg              msgMark [0:4*DEPTH-1];
   // per-phase/word flag: vector here belongs to a long address
   reg              longMark [0:4*DEPTH-1];

   reg [1:0]        state_q;
   reg [2:0]        phases_q;
   reg [1:0]        phase_q;
   reg [3:0]        block_q;
   reg [2:0]        offset_q;
   reg              biwEn_q;
   reg              pend_q;
   reg [PKT_W-1:0]  pkt_q;
   reg              clrAll_q;
   reg [WN_W:0]     clrIdx_q;

   // eight words per block, so block and offset simply concatenate
   wire [WN_W+6:0]  curWnAll = {{WN_W{1'b0}}, block_q, offset_q};
   wire [WN_W-1:0]  curWn   = curWnAll[WN_W-1:0];
   wire [WN_W+1:0]  curAddr = {phase_q, curWn};
   wire [2:0]       curKind = kindMem[curAddr];
   wire [WN_W-1:0]  curLink = linkMem[curAddr];
   wire [WN_W-1:0]  curLen  = lenMem[curAddr];
   wire             curLong = longMark[curAddr];
   // long count includes the word after the vector, which is not in the span
   wire [WN_W-1:0]  spanLen = (curLong && curLen != {WN_W{1'b0}}) ?
                              curLen - {{(WN_W-1){1'b0}}, 1'b1} : curLen;
   wire             inReady;
   wire [31:0]      lastBlkNum = BLOCKS - 1;
   wire             lastOff = ({1'b0, offset_q} == `BLOCK_WORDS - 4'h1);
   wire             lastPh  = ({1'b0, phase_q} == phases_q - 3'h1);
   wire             lastBlk = ({28'h0, block_q} == lastBlkNum);
   wire             clrDone = clrIdx_q[WN_W];

   assign busy = (state_q != S_IDLE);

   skid_buffer #(.WIDTH(PKT_W)) outFifo ( // see RQ13
      .clock    (clock),
      .rstn     (rstn),
      .inValid  (pend_q),
      .inReady  (inReady),
      .inData   (pkt_q),
      .outValid (pktValid),
      .outReady (pktReady),
      .outData  ({pktType, pktPhase, pktWordNum, pktData})
   );

   // store writes; marks are set by vectors and long addresses during the walk
   always @(posedge clock) begin
      if (wordWe && !busy) begin
         kindMem[{wordPhase, wordNumber}] <= wordKind;
         dataMem[{wordPhase, wordNumber}] <= wordData;
         linkMem[{wordPhase, wordNumber}] <= wordLink;
         lenMem[{wordPhase, wordNumber}]  <= wordLen;
      end
   end

   // message marks: vector sets its span, frame start clears all
   genvar g;
   generate
      for (g = 0; g < 4 * DEPTH; g = g + 1) begin : markGen
         localparam [31:0] GW = g % DEPTH;
         localparam [31:0] GP = g / DEPTH;
         wire [WN_W-1:0] gw = GW[WN_W-1:0];
         wire [1:0]      gp = GP[1:0];
         wire inSpan = (gw >= curLink) && ({1'b0, gw} < {1'b0, curLink} + {1'b0, spanLen});
         // long vector: the word right after it opens the message
         wire isNext = curLong && ({1'b0, gw} == {1'b0, curWn} + {{WN_W{1'b0}}, 1'b1});
         wire hit = (state_q == S_SCAN) && (curKind == `WKIND_VECTOR) && (gp == phase_q) &&
                    (inSpan || isNext);
         // long address precedes its vector, so the mark is in place in time
         wire longHit = (state_q == S_SCAN) && (curKind == `WKIND_LONG_ADDR1) &&
                        (gp == phase_q) && (gw == curLink);
         always @(posedge clock or negedge rstn) begin
            if (!rstn) begin
               msgMark[g]  <= 1'b0;
               longMark[g] <= 1'b0;
            end else if (frameStart && !busy) begin
               msgMark[g]  <= 1'b0;
               longMark[g] <= 1'b0;
            end else begin
               if (hit) begin // see RQ5
                  msgMark[g] <= 1'b1;
               end
               if (longHit) begin // see RQ8
                  longMark[g] <= 1'b1;
               end
            end
         end
      end
   endgenerate

   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_q  <= S_IDLE;
         phases_q <= `PHASES_1600;
         phase_q  <= 2'h0;
         block_q  <= 4'h0;
         offset_q <= 3'h0;
         biwEn_q  <= 1'b0;
         pend_q   <= 1'b0;
         pkt_q    <= {PKT_W{1'b0}};
         clrAll_q <= 1'b0;
         clrIdx_q <= {(WN_W+1){1'b0}};
      end else begin
         case (state_q)
            S_IDLE: begin
               if (frameStart) begin
                  case (signalRate) // see RQ9
                     `RATE_3200: phases_q <= `PHASES_3200;
                     `RATE_6400: phases_q <= `PHASES_6400;
                     default:    phases_q <= `PHASES_1600;
                  endcase
                  biwEn_q  <= blockInfoEn;
                  phase_q  <= 2'h0;
                  block_q  <= 4'h0;
                  offset_q <= 3'h0;
                  state_q  <= S_SCAN;
               end
            end
            S_SCAN: begin
               pend_q <= 1'b0;
               pkt_q  <= {PKT_W{1'b0}};
               case (curKind) // see RQ4
                  `WKIND_BLOCK_INFO: begin
                     if (curWn != {WN_W{1'b0}} && biwEn_q) begin // see RQ2 see RQ3
                        pend_q <= 1'b1;
                        pkt_q  <= {`PKT_BLOCK_INFO, phase_q, curWn, dataMem[curAddr]};
                     end
                  end
                  `WKIND_ADDRESS: begin // see RQ6
                     pend_q <= 1'b1;
                     pkt_q  <= {`PKT_ADDRESS, phase_q, curLink, dataMem[curAddr]};
                  end
                  `WKIND_LONG_ADDR1: begin // see RQ7
                     pend_q <= 1'b1;
                     pkt_q  <= {`PKT_LONG_ADDRESS, phase_q, curLink, dataMem[curAddr]};
                  end
                  `WKIND_VECTOR: begin
                     pend_q <= 1'b1;
                     pkt_q  <= {`PKT_VECTOR, phase_q, curWn, dataMem[curAddr]};
                  end
                  `WKIND_MESSAGE: begin // see RQ8 see RQ10
                     // long vectors also mark the word that follows them
                     if (msgMark[curAddr]) begin
                        pend_q <= 1'b1;
                        pkt_q  <= {`PKT_MESSAGE, phase_q, curWn, dataMem[curAddr]};
                     end
                  end
                  default: pend_q <= 1'b0;
               endcase
               state_q <= S_EMIT;
            end
            S_EMIT: begin
               // stall here until the fifo takes the packet
               if (!pend_q || inReady) begin
                  pend_q  <= 1'b0;
                  state_q <= S_SCAN;
                  if (!lastOff) begin // see RQ1
                     offset_q <= offset_q + 3'h1;
                  end else begin
                     offset_q <= 3'h0;
                     if (!lastPh) begin
                        phase_q <= phase_q + 2'h1;
                     end else begin
                        phase_q <= 2'h0;
                        if (lastBlk) begin
                           state_q <= S_IDLE;
                        end else begin
                           block_q <= block_q + 4'h1;
                        end
                     end
                  end
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end
endmodule // paging_message_packet_sequencer

// ===== inc/pager_seq_regs.vh
// constants for the paging message packet sequencer
`ifndef PAGER_SEQ_REGS_VH
`define PAGER_SEQ_REGS_VH
`define PKT_ADDRESS      3'h0
`define PKT_LONG_ADDRESS 3'h1
`define PKT_VECTOR       3'h2
`define PKT_MESSAGE      3'h3
`define PKT_BLOCK_INFO   3'h4
`define WKIND_NONE       3'h0
`define WKIND_BLOCK_INFO 3'h1
`define WKIND_ADDRESS    3'h2
`define WKIND_LONG_ADDR1 3'h3
`define WKIND_LONG_ADDR2 3'h4
`define WKIND_VECTOR     3'h5
`define WKIND_MESSAGE    3'h6
`define RATE_1600        2'h0
`define RATE_3200        2'h1
`define RATE_6400        2'h2
`define PHASES_1600      3'h1
`define PHASES_3200      3'h2
`define PHASES_6400      3'h4
`define BLOCK_WORDS      4'h8
`define SKID_DEPTH       2
`endif

// ===== hw/skid_buffer.v
// two-entry fifo between the sequencer and the packet link
`timescale 1ns/1ps
module skid_buffer #(
   parameter WIDTH = 32
) (
   input  wire             clock,    // system clock
   input  wire             rstn,     // async reset, active low
   input  wire             inValid,  // word offered
   output wire             inReady,  // room available
   input  wire [WIDTH-1:0] inData,   // word in
   output wire             outValid, // word available
   input  wire             outReady, // receiver takes word
   output wire [WIDTH-1:0] outData   // oldest word
);
   reg [WIDTH-1:0] mem [0:1];
   reg             wrPtr_q;
   reg             rdPtr_q;
   reg [1:0]       count_q;
   wire            push = inValid & inReady;
   wire            pop  = outValid & outReady;

   assign inReady  = (count_q != 2'h2);
   assign outValid = (count_q != 2'h0);
   assign outData  = mem[rdPtr_q];

   always @(posedge clock) begin
      if (push) begin
         mem[wrPtr_q] <= inData;
      end
   end

   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         wrPtr_q <= 1'b0;
         rdPtr_q <= 1'b0;
         count_q <= 2'h0;
      end else begin
         if (push) begin
            wrPtr_q <= ~wrPtr_q;
         end
         if (pop) begin
            rdPtr_q <= ~rdPtr_q;
         end
         count_q <= count_q + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule // skid_buffer

// ===== verification/pager_seq_checker_asserts.sv
// checker for the packet sequencer host-side outputs
`timescale 1ns/1ps
`include "pager_seq_regs.vh"
module pager_seq_checker #(parameter WN_W = 7, DATA_W = 21, BLOCKS = 11) (
   input logic              clock,      // clock
   input logic              rstn,       // reset
   input logic              frameStart, // go
   input logic [1:0]        signalRate, // rate
   input logic              busy,       // walking
   input logic              pktValid,   // offered
   input logic              pktReady,   // taken
   input logic [2:0]        pktType,    // type
   input logic [1:0]        pktPhase,   // phase
   input logic [WN_W-1:0]   pktWordNum, // word
   input logic [DATA_W-1:0] pktData     // payload
);
   logic [1:0]      rate_q;
   logic [WN_W+2:0] last_q;
   wire  [2:0]      nPhase = rate_q == `RATE_1600 ? 3'h1 : rate_q == `RATE_3200 ? 3'h2 : 3'h4;
   wire             isMsg  = pktValid && pktType == `PKT_MESSAGE;
   // last message taken; cleared per frame since numbering restarts
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rate_q <= 2'h0;
         last_q <= '0;
      end else if (frameStart && !busy) begin
         rate_q <= signalRate;
         last_q <= '0;
      end else if (isMsg && pktReady)
         last_q <= {1'b1, pktPhase, pktWordNum};
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   sequence s_start; frameStart && !busy; endsequence
   sequence s_stall; pktValid && !pktReady; endsequence
   property p_start; s_start |=> busy; endproperty
   a_start: assert property (p_start) else $error("start ignored");
   property p_cause; $rose(busy) |-> $past(frameStart); endproperty
   a_cause: assert property (p_cause) else $error("walk unasked");
   property p_keep; s_stall |=> pktValid; endproperty
   a_keep: assert property (p_keep) else $error("packet dropped");
   property p_hold; s_stall |=> $stable({pktType, pktPhase, pktWordNum, pktData}); endproperty
   a_hold: assert property (p_hold) else $error("packet changed");
   property p_type; pktValid |-> pktType <= `PKT_BLOCK_INFO; endproperty
   a_type: assert property (p_type) else $error("bad type");
   property p_phase; pktValid |-> pktPhase < nPhase; endproperty
   a_phase: assert property (p_phase) else $error("bad phase");
   property p_word; isMsg |-> pktWordNum != 0 && pktWordNum < BLOCKS * 8; endproperty
   a_word: assert property (p_word) else $error("bad word");
   property p_biw; pktValid && pktType == `PKT_BLOCK_INFO |-> pktWordNum != 0; endproperty
   a_biw: assert property (p_biw) else $error("word 0 info sent");
   property p_order; isMsg && last_q[WN_W+2] && pktPhase == last_q[WN_W+1:WN_W]
      |-> pktWordNum > last_q[WN_W-1:0]; endproperty
   a_order: assert property (p_order) else $error("message order");
endmodule // pager_seq_checker
bind paging_message_packet_sequencer pager_seq_checker #(.WN_W(WN_W), .DATA_W(DATA_W),
   .BLOCKS(BLOCKS)) chk_u (.clock(clock), .rstn(rstn), .frameStart(frameStart),
   .signalRate(signalRate), .busy(busy), .pktValid(pktValid), .pktReady(pktReady),
   .pktType(pktType), .pktPhase(pktPhase), .pktWordNum(pktWordNum), .pktData(pktData));

// ===== verification/host_link_model.sv
// host link model: takes packets, sometimes slowly, in arrival order
`timescale 1ns/1ps
module host_link_model (
   input  logic        clock,    // clock
   input  logic        rstn,     // reset
   input  logic        slow,     // ready one cycle in four
   input  logic        pktValid, // offered
   output logic        pktReady, // taken
   input  logic [32:0] pkt       // type, phase, word, data
);
   logic [32:0] got[$];
   logic [1:0]  cnt_q;
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pktReady <= 1'b0;
         cnt_q    <= 2'h0;
      end else begin
         cnt_q    <= cnt_q + 2'h1;
         pktReady <= !slow || cnt_q == 2'h3;
         // kept whole so address, vector and message can be related later
         if (pktValid && pktReady)
            got.push_back(pkt);
      end
   end
endmodule // host_link_model

// ===== verification/paging_message_packet_sequencer_tb.sv
// self-checking bench for the paging message packet sequencer
`timescale 1ns/1ps
`include "pager_seq_regs.vh"
module paging_message_packet_sequencer_tb;
   logic        clock, rstn, frameStart, blockInfoEn, wordWe, busy, pktValid, pktReady, slow;
   logic [1:0]  signalRate, wordPhase, pktPhase;
   logic [2:0]  wordKind, pktType;
   logic [6:0]  wordNumber, wordLink, wordLen, pktWordNum;
   logic [20:0] wordData, pktData;
   logic [32:0] exp[$];
   int          err_total, n_checks;
   // phase, word, kind, link, length, packet due; decoys carry a 0
   int fr[24][6] = '{'{0,0,1,0,0,0}, '{0,3,2,7,0,1}, '{0,4,2,8,0,1}, '{0,7,5,9,3,1},
      '{0,8,5,12,4,1}, '{0,9,6,0,0,1}, '{0,10,6,0,0,1}, '{0,11,6,0,0,1}, '{0,12,6,0,0,1},
      '{0,13,6,0,0,1}, '{0,14,6,0,0,1}, '{0,15,6,0,0,1}, '{0,16,6,0,0,0}, '{1,0,1,0,0,0},
      '{1,1,1,0,0,1}, '{1,3,1,0,0,1}, '{1,5,3,10,0,1}, '{1,6,4,10,0,0}, '{1,10,5,14,3,1},
      '{1,11,6,0,0,1}, '{1,12,6,0,0,0}, '{1,14,6,0,0,1}, '{1,15,6,0,0,1}, '{2,2,2,20,0,1}};
   logic [2:0]  tmap[7] = '{3'h0, `PKT_BLOCK_INFO, `PKT_ADDRESS, `PKT_LONG_ADDRESS, 3'h0,
      `PKT_VECTOR, `PKT_MESSAGE};
   paging_message_packet_sequencer dut_u (.clock(clock), .rstn(rstn), .frameStart(frameStart),
      .signalRate(signalRate), .blockInfoEn(blockInfoEn), .wordWe(wordWe), .wordLen(wordLen),
      .wordPhase(wordPhase), .wordNumber(wordNumber), .wordKind(wordKind), .wordData(wordData),
      .wordLink(wordLink), .busy(busy), .pktValid(pktValid), .pktReady(pktReady),
      .pktType(pktType), .pktPhase(pktPhase), .pktWordNum(pktWordNum), .pktData(pktData));
   host_link_model host_u (.clock(clock), .rstn(rstn), .slow(slow), .pktValid(pktValid),
      .pktReady(pktReady), .pkt({pktType, pktPhase, pktWordNum, pktData}));
   task automatic chk(input logic [32:0] seen, input logic [32:0] want);
      n_checks++;
      if (seen !== want) begin
         err_total++;
         $display("Error at %0t: saw %h expected %h", $time, seen, want);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic wr(input int p, w, k, l, n);
      @(posedge clock);
      {wordWe, wordPhase, wordNumber, wordKind} <= {1'b1, 2'(p), 7'(w), 3'(k)};
      {wordLink, wordLen, wordData} <= {7'(l), 7'(n), 12'h000, 2'(p), 7'(w)};
   endtask
   task automatic run(input logic [1:0] r, input logic b, s, input int nph);
      int i;
      for (int bl = 0; bl < 11; bl++)
         for (int p = 0; p < nph; p++)
            foreach (fr[j])
               if (fr[j][0] == p && fr[j][1] / 8 == bl && fr[j][5] == 1 && (b || fr[j][2] != 1))
                  exp.push_back({tmap[fr[j][2]], 2'(p), 7'(fr[j][2] inside {2, 3} ? fr[j][3]
                     : fr[j][1]), 12'h000, 2'(p), 7'(fr[j][1])});
      @(posedge clock);
      {wordWe, signalRate, blockInfoEn, slow, frameStart} <= {1'b0, r, b, s, 1'b1};
      @(posedge clock);
      frameStart <= 1'b0;
      // a repeated start in mid-walk must be ignored
      for (i = 0; i < 5000 && (i < 4 || busy !== 1'b0 || pktValid !== 1'b0); i++) begin
         @(posedge clock);
         frameStart <= (i == 20);
      end
      chk(33'(i < 5000), 33'h1);
      chk(33'(host_u.got.size()), 33'(exp.size()));
      for (i = 0; i < exp.size() && i < host_u.got.size(); i++)
         chk(host_u.got[i], exp[i]);
      host_u.got.delete();
      exp.delete();
   endtask
   task automatic t_window;
      run(`RATE_3200, 1'b1, 1'b0, 2);
      $display("two-phase frame, info words on: done");
   endtask
   task automatic t_stall_noinfo;
      run(`RATE_3200, 1'b0, 1'b1, 2);
      $display("stalling host, info words off: done");
   endtask
   task automatic t_rates;
      run(`RATE_1600, 1'b1, 1'b1, 1);
      run(`RATE_6400, 1'b0, 1'b0, 4);
      $display("one and four phases: done");
   endtask
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   initial begin
      #1000000;
      err_total++;
      stop_test();
   end
   initial begin
      {rstn, frameStart, signalRate, blockInfoEn, wordWe, wordPhase, wordNumber} = '0;
      {wordKind, wordData, wordLink, wordLen, slow} = '0;
      repeat (12) @(posedge clock);
      rstn <= 1'b1;
      // store is undefined after reset, so words 0 to 87 of all four phases are written first
      for (int i = 0; i < 352; i++)
         wr(i / 88, i % 88, 0, 0, 0);
      foreach (fr[j])
         wr(fr[j][0], fr[j][1], fr[j][2], fr[j][3], fr[j][4]);
      t_window();
      t_stall_noinfo();
      t_rates();
      stop_test();
   end
endmodule // paging_message_packet_sequencer_tb
